// File: core/analog_multiplex_register_pkg.sv
// Package for the analog multiplex control block: register map, fields, reset values.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package analog_multiplex_register_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] MUX_REG_OFF    = 4'h0;
  localparam logic [3:0] STATUS_REG_OFF = 4'h4;
  localparam logic [3:0] MASK_REG_OFF   = 4'h8;
  localparam logic [3:0] CTRL_REG_OFF   = 4'hC;

  // ==========================================================================
  // Multiplex register fields
  localparam int MUX_SEL_LSB    = 0;
  localparam int REF_SEL_BIT    = 4;
  localparam int SWAP_BIT       = 5;
  localparam int HALVED_BIT     = 6;
  localparam int DIRECT_BIT     = 7;
  localparam logic [7:0] MUX_RESET = 8'h80;

  // Status / mask / control fields
  localparam int FLAG1_BIT      = 0;
  localparam int FLAG2_BIT      = 1;
  localparam int OFFSET_OPT_BIT = 0;
  localparam int HOLD_OFF_BIT   = 1;

  // ==========================================================================
  // Comparator 2 negative-input source
  typedef enum logic [1:0] {SRC_HOLD, SRC_HALVED, SRC_DIRECT, SRC_DIODE} sample_src_e;

  typedef struct packed {
    logic       direct_sample_select;
    logic       halved_sample_select;
    logic       comparator_swap;
    logic       supply_ref_select;
    logic [3:0] channel_pin_select;
  } mux_reg_s;

  typedef struct packed {
    logic [3:0] pin_connect;
    logic       supply_connect;
    logic       ground_connect;
  } bus_route_s;

endpackage : analog_multiplex_register_pkg

// File: core/analog_input_mux_control.sv
// Analog multiplex register with channel bus and sample source decode.
// Assumes comparator levels arrive asynchronously from the analog front end.
//
// Contract
// R1: Both sample-select bits clear: capacitor isolated from bus, held on comparator 2.
// R2: Hold case applies ground offset only when offset option and hold-offset both set.
// R3: Halved select alone routes channel bus halved to capacitor and comparator 2.
// R4: Direct select alone routes channel bus unscaled to capacitor and comparator 2.
// R5: Both sample-select bits set connect the temperature diode to the capacitor.
// R6: Software clears sample-select bits before changing channel bits in a later write.
// R7: Swap bit exchanges comparator inputs and inverts outputs; zero means no swap.
// R8: Each flag rises only when positive pin exceeds negative pin, regardless of swap.
// R9: Toggling the swap bit may set either comparator flag spuriously.
// R10: Software avoids swap changes while waiting and then clears both flags.
// R11: Reset clears the swap bit and the supply-reference select bit.
// R12: Supply rail joins channel bus only with reference bit set, all channels clear.
// R13: Each channel bit independently connects its own pin; any combination allowed.
// R14: Reference bit and all channel bits clear connect bus to internal analog ground; bus_route connects nothing until the first clock after reset.
// R15: Any channel bit set disconnects supply and ground; unselected sources float.
// R16: Reset sets direct select, clears halved select and all channel bits.
// R17: Hold-offset bit acts only when the offset option bit enables it.
// R18: All multiplex bits live together in one 8-bit read/write register.
// R19: Multiplex register reads back last written value except after reset.
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
module analog_input_mux_control
  import analog_multiplex_register_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        comp1_raw,
  input  wire logic        comp2_raw,
  output bus_route_s       bus_route,
  output sample_src_e      sample_source,
  output logic             hold_ground_offset_on,
  output logic             comparator_inputs_swapped,
  output logic             comparator1_flag,
  output logic             comparator2_flag,
  output logic             irq
);

  // ==========================================================================
  // Decode helpers
  function automatic sample_src_e decode_src(input mux_reg_s r);
    case ({r.direct_sample_select, r.halved_sample_select})
      2'b00:   decode_src = SRC_HOLD;      // see R1
      2'b01:   decode_src = SRC_HALVED;    // see R3
      2'b10:   decode_src = SRC_DIRECT;    // see R4
      default: decode_src = SRC_DIODE;     // see R5
    endcase
  endfunction : decode_src

  function automatic bus_route_s decode_bus(input mux_reg_s r);
    decode_bus.pin_connect    = r.channel_pin_select;                          // see R13, R15
    decode_bus.supply_connect = r.supply_ref_select && (r.channel_pin_select == 4'h0);  // see R12
    decode_bus.ground_connect = !r.supply_ref_select && (r.channel_pin_select == 4'h0); // see R14
  endfunction : decode_bus

  // ==========================================================================
  // Register state
  mux_reg_s    mux_q,   mux_d;
  logic [1:0]  ctrl_q,  ctrl_d;
  logic [1:0]  stat_q,  stat_d;
  logic [1:0]  mask_q,  mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wait_q,  wait_d;
  logic [1:0]  c_meta_q, c_sync_q, c_prev_q;
  bus_route_s  route_q;
  sample_src_e src_q;
  logic        offset_q, swap_q, f1_q, f2_q, irq_q;

  logic        acc;
  logic        wr_hit;
  logic [7:0]  wbyte;
  logic [1:0]  rise;
  logic [31:0] rd_mux;

  // Zero wait on the first access cycle would be fine, but one cycle keeps readdata registered
  // A request is taken at the edge where waitrequest already stands low
  assign acc    = (avs_read || avs_write) && !wait_q;
  assign wr_hit = avs_write && !wait_q && avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];
  // Flags follow pin polarity only: the swap is undone inside the comparator itself
  assign rise   = c_sync_q & ~c_prev_q; // see R7, R8

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    mux_d   = mux_q;
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    wait_d  = !acc && (avs_read || avs_write) ? 1'b0 : 1'b1;
    rd_mux  = 32'h0000_0000;
    case (avs_address)
      MUX_REG_OFF:    rd_mux = {24'h00_0000, mux_q};   // see R19
      STATUS_REG_OFF: rd_mux = {30'h0000_0000, stat_q};
      MASK_REG_OFF:   rd_mux = {30'h0000_0000, mask_q};
      CTRL_REG_OFF:   rd_mux = {30'h0000_0000, ctrl_q};
      default:        rd_mux = 32'h0000_0000;
    endcase
    rdata_d = (avs_read && !acc) ? rd_mux : rdata_q;
    if (wr_hit)
    begin
      case (avs_address)
        MUX_REG_OFF:    mux_d  = mux_reg_s'(wbyte);   // see R18, R19
        STATUS_REG_OFF: stat_d = stat_q & ~wbyte[1:0];
        MASK_REG_OFF:   mask_d = wbyte[1:0];
        CTRL_REG_OFF:   ctrl_d = wbyte[1:0];
        default:        ;
      endcase
    end
    // Set wins over a simultaneous clear; a swap toggle may set flags too
    stat_d = stat_d | rise; // see R9
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mux_q    <= mux_reg_s'(MUX_RESET); // see R11, R16
      ctrl_q   <= 2'b00;
      stat_q   <= 2'b00;
      mask_q   <= 2'b00;
      rdata_q  <= 32'h0000_0000;
      wait_q   <= 1'b1;
      c_meta_q <= 2'b00;
      c_sync_q <= 2'b00;
      c_prev_q <= 2'b00;
      route_q  <= '0;
      src_q    <= SRC_DIRECT;
      offset_q <= 1'b0;
      swap_q   <= 1'b0;
      f1_q     <= 1'b0;
      f2_q     <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      mux_q    <= mux_d;
      ctrl_q   <= ctrl_d;
      stat_q   <= stat_d;
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
      wait_q   <= wait_d;
      c_meta_q <= {comp2_raw, comp1_raw};
      c_sync_q <= c_meta_q;
      c_prev_q <= c_sync_q;
      route_q  <= decode_bus(mux_q);
      src_q    <= decode_src(mux_q);
      // Offset only in hold, and only when the option enables it
      offset_q <= (decode_src(mux_q) == SRC_HOLD) && ctrl_q[OFFSET_OPT_BIT] && ctrl_q[HOLD_OFF_BIT]; // see R2, R17
      swap_q   <= mux_q.comparator_swap;  // see R7
      f1_q     <= stat_q[FLAG1_BIT];
      f2_q     <= stat_q[FLAG2_BIT];
      irq_q    <= |(stat_q & mask_q);
    end
  end

  assign avs_readdata              = rdata_q;
  assign avs_waitrequest           = wait_q;
  assign bus_route                 = route_q;
  assign sample_source             = src_q;
  assign hold_ground_offset_on     = offset_q;
  assign comparator_inputs_swapped = swap_q;
  assign comparator1_flag          = f1_q;
  assign comparator2_flag          = f2_q;
  assign irq                       = irq_q;

endmodule : analog_input_mux_control

// File: bench/analog_input_mux_control_assertions.sv
// Port-level checker for the analog multiplex control block.
// Assumes one clock domain and the one-cycle bus answer of the slave.
`timescale 1ns/100ps
module analog_multiplex_register_checker
  import analog_multiplex_register_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        comp1_raw,
  input wire logic        comp2_raw,
  input wire bus_route_s  bus_route,
  input wire sample_src_e sample_source,
  input wire logic        hold_ground_offset_on,
  input wire logic        comparator_inputs_swapped,
  input wire logic        comparator1_flag,
  input wire logic        comparator2_flag,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Properties
  property p_pins; |bus_route.pin_connect |-> !bus_route.supply_connect && !bus_route.ground_connect; endproperty
  a_pins: assert property (p_pins) else $error("rail joined with pins");
  property p_ack; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("late bus answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_irq; irq |-> comparator1_flag || comparator2_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");
  // Flag rises four edges after the pin is sampled; depths three and four are both allowed
  property p_f1; $rose(comparator1_flag) |-> $past(comp1_raw, 3) || $past(comp1_raw, 4); endproperty
  a_f1: assert property (p_f1) else $error("flag 1 without pin level");
  property p_f2; $rose(comparator2_flag) |-> $past(comp2_raw, 3) || $past(comp2_raw, 4); endproperty
  a_f2: assert property (p_f2) else $error("flag 2 without pin level");
  property p_swap; $changed(comparator_inputs_swapped) |-> $past(avs_write, 2); endproperty
  a_swap: assert property (p_swap) else $error("swap moved without write");
  property p_hold; hold_ground_offset_on |-> sample_source == SRC_HOLD; endproperty
  a_hold: assert property (p_hold) else $error("offset outside hold");
endmodule : analog_multiplex_register_checker

bind analog_input_mux_control analog_multiplex_register_checker i_analog_multiplex_register_checker (.clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
  .comp1_raw, .comp2_raw, .bus_route, .sample_source, .hold_ground_offset_on, .comparator_inputs_swapped,
  .comparator1_flag, .comparator2_flag, .irq);

// File: bench/analog_input_mux_control_test.sv
// Self-checking bench for the analog multiplex control block.
// Assumes the Avalon slave answers one cycle after a request rises.
`timescale 1ns/100ps
module analog_input_mux_control_test
  import analog_multiplex_register_pkg::*;
;
  logic        clk, reset_n, avs_read, avs_write, avs_waitrequest, comp1_raw, comp2_raw, irq;
  logic        hold_ground_offset_on, comparator_inputs_swapped, comparator1_flag, comparator2_flag;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  bus_route_s  bus_route;
  sample_src_e sample_source;
  int          err_count, total_checks;

  analog_input_mux_control i_analog_input_mux_control (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .comp1_raw, .comp2_raw, .bus_route,
    .sample_source, .hold_ground_offset_on, .comparator_inputs_swapped, .comparator1_flag, .comparator2_flag, .irq);
  // ==========================================
  // Bus and compare helpers
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // ==========================================
  // Scenarios
  task automatic t_reset;
    bus(1'b0, MUX_REG_OFF, 8'h00);
    chk(q, 32'h80);
    chk(32'(bus_route), 32'h01);
    bus(1'b0, 4'h2, 8'h00);
    chk(q, 32'h0);
  endtask : t_reset
  task automatic t_source;
    for (int v = 0; v < 32; v++)
    begin
      bus(1'b1, CTRL_REG_OFF, {6'h00, v[1:0]});
      bus(1'b1, MUX_REG_OFF, {v[4:2], 5'h00});
      @(posedge clk);
      #1;
      chk(32'(sample_source), 32'(v[4:3]));
      chk(32'(hold_ground_offset_on), 32'(v[4:3] == 0 && v[1:0] == 3));
      chk(32'(comparator_inputs_swapped), 32'(v[2]));
    end
  endtask : t_source
  task automatic t_route;
    bus(1'b1, MUX_REG_OFF, 8'h00);
    for (int v = 0; v < 32; v++)
    begin
      bus(1'b1, MUX_REG_OFF, v[7:0]);
      @(posedge clk);
      #1;
      chk(32'(bus_route), 32'({v[3:0], v[4] && v[3:0] == 0, !v[4] && v[3:0] == 0}));
      bus(1'b0, MUX_REG_OFF, 8'h00);
      chk(q, 32'(v));
    end
  endtask : t_route
  task automatic t_flags;
    bus(1'b1, STATUS_REG_OFF, 8'h03);
    bus(1'b1, MASK_REG_OFF, 8'h01);
    comp1_raw <= 1'b1;
    comp2_raw <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({comparator1_flag, comparator2_flag, irq}, 32'h7);
    bus(1'b1, STATUS_REG_OFF, 8'h01);
    @(posedge clk);
    #1;
    chk({comparator1_flag, comparator2_flag, irq}, 32'h2);
  endtask : t_flags

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    {reset_n, avs_read, avs_write, comp1_raw, comp2_raw} = 5'h00;
    avs_address   = 4'h0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_source;
    t_route;
    t_flags;
    conclude;
  end
  // Whole run is under a thousand cycles; ten thousand means a hang
  initial
  begin
    #1000000;
    err_count++;
    conclude;
  end
endmodule : analog_input_mux_control_test
